// File: rtl/sasi_pkg.sv
// shared constants and types for the target-side host port
package sasi_pkg;

   // ---------------------------------------------------------------
   // clock and time conversion
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 10000;

   // least times round up, longest times round down, never below one
   function automatic int cyc_min(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int cyc_max(input int ns);
      int c;
      c = (ns * 1000) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int DATA_SETUP_NS    = 125;
   localparam int DATA_SETUP_CYC   = cyc_min(DATA_SETUP_NS);
   localparam int REQ_REL_MIN_NS   = 25;
   localparam int REQ_REL_CYC      = cyc_min(REQ_REL_MIN_NS);
   localparam int REQ_REL_MAX_NS   = 75;
   localparam int REQ_REL_MAX_CYC  = cyc_max(REQ_REL_MAX_NS);
   localparam int REARM_MIN_NS     = 1200;
   localparam int REARM_CYC        = cyc_min(REARM_MIN_NS);
   localparam int REARM_MAX_NS     = 1700;
   localparam int REARM_MAX_CYC    = cyc_max(REARM_MAX_NS);
   localparam int ACK_WAIT_MIN_NS  = 25;
   localparam int ACK_WAIT_CYC     = cyc_min(ACK_WAIT_MIN_NS);
   localparam int ACK_WAIT_MAX_NS  = 50;
   localparam int ACK_WAIT_MAX_CYC = cyc_max(ACK_WAIT_MAX_NS);
   localparam int HOST_DATA_NS     = 250;
   localparam int HOST_DATA_CYC    = cyc_min(HOST_DATA_NS) + 1;
   localparam int RX_REL_MAX_NS    = 1000;
   localparam int RX_REL_MAX_CYC   = cyc_max(RX_REL_MAX_NS);
   localparam int NEXT_REQ_MAX_NS  = 500;
   localparam int NEXT_REQ_MAX_CYC = cyc_max(NEXT_REQ_MAX_NS);
   localparam int PHASE_REQ_MAX_US = 20;
   localparam int PHASE_REQ_CYC    = cyc_max(PHASE_REQ_MAX_US * 1000);

   // ---------------------------------------------------------------
   // command block and status layout
   // ---------------------------------------------------------------
   localparam int CMD_BYTES       = 6;
   localparam int CLASS_LSB       = 5;
   localparam int UNIT_BIT        = 5;
   localparam int CTL_NO_RETRY    = 7;
   localparam int CTL_NO_REREAD   = 6;
   localparam int CTL_SERVO       = 4;
   localparam int STAT_ERR_BIT    = 1;
   localparam int STAT_UNIT_BIT   = 5;
   localparam logic [1:0] RETRY_COUNT = 2'h3;
   localparam logic [2:0] CLASS_DATA  = 3'h0;
   localparam logic [2:0] CLASS_DIAG  = 3'h7;
   localparam logic [3:0] STEP_FIRST_BUF = 4'h4;
   localparam logic [3:0] STEP_LAST_BUF  = 4'h8;

   typedef logic [11:0] step_us_type;
   localparam step_us_type STEP_DEFAULT_US = 12'd3000;
   localparam step_us_type STEP_200_US     = 12'd200;
   localparam step_us_type STEP_70_US      = 12'd70;
   localparam step_us_type STEP_30_US      = 12'd30;
   localparam step_us_type STEP_15_US      = 12'd15;
   localparam step_us_type STEP_12_US      = 12'd12;

   typedef logic [CMD_BYTES-1:0][7:0] block_type;

endpackage

// File: rtl/byte_skid_buffer.sv
// small valid/ready buffer in the path of bytes sent to the host
`timescale 1ns/10ps
module byte_skid_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             reset,
   // filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (1 << PW) != DEPTH)
      $error("buffer depth must be a power of two, at least 2");

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               rd;
      logic [PW-1:0]               wr;
      logic [PW:0]                 cnt;
   } buf_state_type;

   buf_state_type s_r;
   buf_state_type s_nxt;
   logic          push;
   logic          pop;

   assign in_ready  = (s_r.cnt != (PW+1)'(DEPTH));
   assign out_valid = (s_r.cnt != '0);
   assign out_data  = s_r.mem[s_r.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb
   begin
      s_nxt = s_r;
      if (push)
      begin
         s_nxt.mem[s_r.wr] = in_data;
         s_nxt.wr          = s_r.wr + PW'(1);
      end
      if (pop)
         s_nxt.rd = s_r.rd + PW'(1);
      s_nxt.cnt = s_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end
endmodule

// File: rtl/command_block_decoder.sv
// field and control byte decode of the six-byte command block
`timescale 1ns/10ps
module command_block_decoder (
   // captured command block
   input  wire sasi_pkg::block_type command_block,
   // byte 0
   output logic [2:0]             cmd_class,
   output logic [4:0]             cmd_opcode,
   output logic                   cmd_class_valid,
   // bytes 1 to 4
   output logic                   cmd_unit,
   output logic [20:0]            cmd_logical_address,
   output logic [7:0]             cmd_count,
   // control byte
   output logic [1:0]             retry_limit,
   output logic                   recal_on_fail,
   output logic                   reread_before_ecc,
   output logic                   embedded_servo,
   output logic                   step_code_valid,
   output logic                   step_buffered,
   output sasi_pkg::step_us_type  step_period_us
);
   import sasi_pkg::*;

   function automatic step_us_type step_of(input logic [3:0] code);
      unique case (code)
         4'h0:    return STEP_DEFAULT_US;
         4'h4:    return STEP_200_US;
         4'h5:    return STEP_70_US;
         4'h6:    return STEP_30_US;
         4'h7:    return STEP_15_US;
         4'h8:    return STEP_12_US;
         default: return STEP_DEFAULT_US;
      endcase
   endfunction

   logic [7:0] ctl;

   assign ctl        = command_block[5];
   assign cmd_class  = command_block[0][7:CLASS_LSB];
   assign cmd_opcode = command_block[0][CLASS_LSB-1:0];
   assign cmd_class_valid = (cmd_class == CLASS_DATA) ||
                            (cmd_class == CLASS_DIAG);
   assign cmd_unit   = command_block[1][UNIT_BIT];
   assign cmd_logical_address = {command_block[1][4:0],
                                 command_block[2],
                                 command_block[3]};
   assign cmd_count  = command_block[4];
   // three retries, then recalibrate, seek back and one last try
   assign retry_limit   = ctl[CTL_NO_RETRY] ? 2'h0 : RETRY_COUNT;
   assign recal_on_fail = !ctl[CTL_NO_RETRY];
   assign reread_before_ecc = !ctl[CTL_NO_REREAD];
   assign embedded_servo    = ctl[CTL_SERVO];
   // reserved and spare codes fall back to the default rate
   assign step_buffered   = (ctl[3:0] >= STEP_FIRST_BUF) &&
                            (ctl[3:0] <= STEP_LAST_BUF);
   assign step_code_valid = step_buffered || (ctl[3:0] == 4'h0);
   assign step_period_us  = step_of(ctl[3:0]);
endmodule

// File: rtl/sasi_target_host_interface.sv
// target end of the parallel host bus: select, command, data, status
//
// Behaviour
// - busy only after select plus own address
// - command request: cd low, io high, msg high
// - request within 20 us of phase lines
// - command is six bytes, one handshake each
// - data set up 125 ns before request
// - to host, drop request 25-75 ns after ack
// - to host, re-request 1.2-1.7 us later
// - never request while ack is active
// - from host, drop request within 1000 ns
// - from host, next request within 500 ns
// - two status bytes: error/unit, then zero
// - byte 0 gives class and opcode
// - bytes 1-5 give unit, address, count, control
// - control bit 7 disables retry and recalibrate
// - control bit 6 skips reread before correction
// - control bit 4 marks embedded servo drives
// - control bits 3-0 choose step rate
`timescale 1ns/10ps
module sasi_target_host_interface #(
   parameter int CTRL_ADDR = 0
) (
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  reset,
   // host bus, control lines
   input  wire logic                  sel_n,
   input  wire logic                  ack_n,
   output logic                       busy_n,
   output logic                       req_n,
   output logic                       cd_n,
   output logic                       io_n,
   output logic                       msg_n,
   // host bus, data lines (active low, two-way)
   input  wire logic [7:0]            db_n_in,
   output logic [7:0]                 db_n_out,
   output logic                       db_n_oe_n,
   // decoded command
   output logic                       cmd_valid,
   output logic [2:0]                 cmd_class,
   output logic [4:0]                 cmd_opcode,
   output logic                       cmd_class_valid,
   output logic                       cmd_unit,
   output logic [20:0]                cmd_logical_address,
   output logic [7:0]                 cmd_count,
   // control byte settings
   output logic [1:0]                 retry_limit,
   output logic                       recal_on_fail,
   output logic                       reread_before_ecc,
   output logic                       embedded_servo,
   output logic                       step_code_valid,
   output logic                       step_buffered,
   output sasi_pkg::step_us_type      step_period_us,
   // bytes to the host
   input  wire logic                  tx_valid,
   output logic                       tx_ready,
   input  wire logic [7:0]            tx_data,
   // command completion
   input  wire logic                  done_valid,
   input  wire logic                  done_error,
   output logic                       done_ready,
   // status
   output logic                       selected
);
   import sasi_pkg::*;

   if (CTRL_ADDR < 0 || CTRL_ADDR > 7)
      $error("controller address must be a data line 0 to 7");

   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_CMD  = 3'b001,
      PH_DATA = 3'b010,
      PH_STAT = 3'b011,
      PH_FIN  = 3'b100
   } phase_type;

   typedef struct packed {
      phase_type  phase;
      logic       busy;
      logic       req;
      logic       cd_n;
      logic       io_n;
      logic       msg_n;
      logic       drive;
      logic [7:0] dout;
      logic [2:0] idx;
      block_type  blk;
      logic [7:0] gap;
      logic [2:0] ack_hi;
      logic [4:0] ack_lo;
      logic [3:0] dset;
      logic       have;
      logic       err;
      logic       cmdv;
   } port_state_type;

   function automatic logic [7:0] status_byte(input logic err,
                                              input logic unit);
      logic [7:0] b;
      b                = 8'h00;
      b[STAT_ERR_BIT]  = err;
      b[STAT_UNIT_BIT] = unit;
      return b;
   endfunction

   port_state_type s_r;
   port_state_type s_nxt;
   logic           ack;
   logic           to_host;
   logic           sel_hit;
   logic           req_go;
   logic           rel_go;
   logic           buf_valid;
   logic           buf_ready;
   logic [7:0]     buf_data;

   assign ack     = !ack_n;
   assign to_host = (s_r.phase == PH_DATA) || (s_r.phase == PH_STAT);
   assign sel_hit = !sel_n && !db_n_in[CTRL_ADDR];
   // a request waits for ack idle; to the host also for setup time and re-arm spacing
   assign req_go  = s_r.have && !s_r.req && sel_n &&
                    (s_r.ack_hi >= 3'(ACK_WAIT_CYC)) &&
                    (!to_host ||
                     ((s_r.gap >= 8'(REARM_CYC)) &&
                      (s_r.dset >= 4'(DATA_SETUP_CYC))));
   // from host the byte is sampled late enough to be valid
   assign rel_go  = s_r.req && ack &&
                    (to_host ? (s_r.ack_lo >= 5'(REQ_REL_CYC - 1))
                             : (s_r.ack_lo >= 5'(HOST_DATA_CYC - 1)));
   assign buf_ready  = (s_r.phase == PH_DATA) && !s_r.have;
   // completion only once every offered byte has gone out
   assign done_ready = (s_r.phase == PH_DATA) && !s_r.have &&
                       !buf_valid && !tx_valid;

   always_comb
   begin
      s_nxt      = s_r;
      s_nxt.cmdv = 1'b0;
      s_nxt.ack_hi = ack ? 3'h0 :
                     ((s_r.ack_hi == 3'h7) ? s_r.ack_hi : s_r.ack_hi + 3'h1);
      s_nxt.ack_lo = !ack ? 5'h00 :
                     ((s_r.ack_lo == 5'h1f) ? s_r.ack_lo : s_r.ack_lo + 5'h01);
      s_nxt.gap  = (s_r.gap == 8'hff) ? s_r.gap : s_r.gap + 8'h01;
      s_nxt.dset = (s_r.dset == 4'hf) ? s_r.dset : s_r.dset + 4'h1;
      if (req_go)
         s_nxt.req = 1'b1;
      if (rel_go)
      begin
         s_nxt.req  = 1'b0;
         s_nxt.gap  = 8'h00;
         s_nxt.have = 1'b0;
      end
      unique case (s_r.phase)
         PH_IDLE:
         begin
            if (sel_hit)
            begin
               s_nxt.busy  = 1'b1;
               s_nxt.phase = PH_CMD;
               s_nxt.cd_n  = 1'b0;
               s_nxt.io_n  = 1'b1;
               s_nxt.msg_n = 1'b1;
               s_nxt.idx   = 3'h0;
               s_nxt.have  = 1'b1;
            end
         end
         PH_CMD:
         begin
            if (rel_go)
            begin
               s_nxt.blk[s_r.idx] = ~db_n_in;
               s_nxt.idx  = s_r.idx + 3'h1;
               s_nxt.have = 1'b1;
               if (s_r.idx == 3'(CMD_BYTES - 1))
               begin
                  s_nxt.phase = PH_DATA;
                  s_nxt.cmdv  = 1'b1;
                  s_nxt.have  = 1'b0;
                  s_nxt.cd_n  = 1'b1;
                  s_nxt.io_n  = 1'b0;
                  s_nxt.drive = 1'b1;
               end
            end
         end
         PH_DATA:
         begin
            if (buf_ready && buf_valid)
            begin
               s_nxt.dout = buf_data;
               s_nxt.have = 1'b1;
               s_nxt.dset = 4'h0;
            end
            else if (done_ready && done_valid)
            begin
               s_nxt.phase = PH_STAT;
               s_nxt.err   = done_error;
               s_nxt.cd_n  = 1'b0;
               s_nxt.idx   = 3'h0;
               s_nxt.dout  = status_byte(done_error, s_r.blk[1][UNIT_BIT]);
               s_nxt.have  = 1'b1;
               s_nxt.dset  = 4'h0;
            end
         end
         PH_STAT:
         begin
            if (rel_go && s_r.idx == 3'h0)
            begin
               s_nxt.idx  = 3'h1;
               s_nxt.dout = 8'h00;
               s_nxt.have = 1'b1;
               s_nxt.dset = 4'h0;
            end
            else if (rel_go)
               s_nxt.phase = PH_FIN;
         end
         PH_FIN:
         begin
            // free the bus only after the host lets go of ack
            if (s_r.ack_hi >= 3'(ACK_WAIT_CYC))
            begin
               s_nxt.phase = PH_IDLE;
               s_nxt.busy  = 1'b0;
               s_nxt.cd_n  = 1'b1;
               s_nxt.io_n  = 1'b1;
               s_nxt.drive = 1'b0;
               s_nxt.err   = 1'b0;
            end
         end
         default:
            s_nxt.phase = PH_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         s_r        <= '0;
         s_r.cd_n   <= 1'b1;
         s_r.io_n   <= 1'b1;
         s_r.msg_n  <= 1'b1;
         s_r.ack_hi <= 3'h7;
         s_r.gap    <= 8'hff;
      end
      else
         s_r <= s_nxt;
   end

   assign busy_n    = !s_r.busy;
   assign req_n     = !s_r.req;
   assign cd_n      = s_r.cd_n;
   assign io_n      = s_r.io_n;
   assign msg_n     = s_r.msg_n;
   assign db_n_out  = ~s_r.dout;
   assign db_n_oe_n = !s_r.drive;
   assign cmd_valid = s_r.cmdv;
   assign selected  = s_r.busy;

   byte_skid_buffer #(
      .WIDTH (8),
      .DEPTH (2)
   ) u_tx_buffer (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .in_data   (tx_data),
      .out_valid (buf_valid),
      .out_ready (buf_ready),
      .out_data  (buf_data)
   );

   command_block_decoder u_decoder (
      .command_block       (s_r.blk),
      .cmd_class           (cmd_class),
      .cmd_opcode          (cmd_opcode),
      .cmd_class_valid     (cmd_class_valid),
      .cmd_unit            (cmd_unit),
      .cmd_logical_address (cmd_logical_address),
      .cmd_count           (cmd_count),
      .retry_limit         (retry_limit),
      .recal_on_fail       (recal_on_fail),
      .reread_before_ecc   (reread_before_ecc),
      .embedded_servo      (embedded_servo),
      .step_code_valid     (step_code_valid),
      .step_buffered       (step_buffered),
      .step_period_us      (step_period_us)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic [3:0] stable_cnt;
   logic [2:0] cmd_bytes;

   always_ff @(posedge clk_sys)
   begin
      if (reset || db_n_out != $past(db_n_out))
         stable_cnt <= 4'h0;
      else if (stable_cnt != 4'hf)
         stable_cnt <= stable_cnt + 4'h1;
      if (reset || $fell(busy_n))
         cmd_bytes <= 3'h0;
      else if ($rose(req_n) && !cd_n && io_n)
         cmd_bytes <= cmd_bytes + 3'h1;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   sequence s_ack_held;
      (!req_n && !ack_n && !io_n) [*3];
   endsequence

   sequence s_cmd_wait;
      (s_r.phase == PH_CMD) && req_n && sel_n && ack_n && s_r.have;
   endsequence

   chk_busy_cause: assert property (
      $fell(busy_n) |-> $past(sel_hit))
      else $error("busy asserted without select and address");
   chk_cmd_lines: assert property (
      (s_r.phase == PH_CMD) |-> (!cd_n && io_n && msg_n && !busy_n))
      else $error("command phase lines wrong");
   chk_six_bytes: assert property (
      cmd_valid |-> (cmd_bytes == 3'h5 && !$past(req_n)))
      else $error("command block not six handshakes");
   chk_data_setup: assert property (
      $fell(req_n) && !io_n |-> (stable_cnt >= 4'd12))
      else $error("data not set up before request");
   chk_tx_release: assert property (
      s_ack_held |=> req_n)
      else $error("request not dropped after ack to host");
   chk_tx_rearm: assert property (
      $rose(req_n) && !io_n ##1 (ack_n && s_r.have) [*3] |->
      ##[117:167] !req_n)
      else $error("re-request to host out of window");
   chk_no_req_ack: assert property (
      $fell(req_n) |-> (ack_n && $past(ack_n) && $past(ack_n, 2)))
      else $error("request raised while ack active");
   chk_rx_release: assert property (
      $fell(ack_n) && !req_n && io_n |-> ##[1:100] req_n)
      else $error("request not dropped after ack from host");
   chk_rx_rearm: assert property (
      s_cmd_wait |-> ##[1:50] !req_n)
      else $error("next command request too late");
   chk_status_byte: assert property (
      $fell(req_n) && !cd_n && !io_n |->
      (db_n_out == ~((s_r.idx == 3'h0) ?
                     status_byte(s_r.err, s_r.blk[1][UNIT_BIT]) : 8'h00)))
      else $error("status byte value wrong");
endmodule

// File: verification/host_adapter_model.sv
// host adapter model on the far side of the parallel host bus
`timescale 1ns/10ps
module host_adapter_model (
   // clock
   input  wire logic       clk_sys,
   // target lines
   input  wire logic       req_n,
   input  wire logic [7:0] db_n_out,
   input  wire logic       db_n_oe_n,
   // host lines
   output logic            sel_n,
   output logic            ack_n,
   output logic [7:0]      db_n_in
);
   logic [7:0] host_db = 8'hff;
   logic [7:0] last_db = 8'hff;
   logic       req_q = 1'b1;
   int         stable = 0;
   int         overlap = 0;
   initial
   begin
      sel_n = 1'b1;
      ack_n = 1'b1;
   end
   // wire level: target wins while its enable is low
   assign db_n_in = db_n_oe_n ? host_db : db_n_out;
   always @(posedge clk_sys)
   begin
      last_db <= db_n_out;
      stable <= (db_n_out === last_db) ? stable + 1 : 0;
      req_q <= req_n;
      if (!ack_n && req_q && !req_n) overlap <= overlap + 1;
   end
   task automatic wait_req(input logic lvl, output int n);
      n = 0;
      while (req_n !== lvl && n < 3000)
      begin
         @(negedge clk_sys);
         n++;
      end
   endtask
   // address bit held 10 cycles past select release
   task automatic select(input int adr);
      @(posedge clk_sys) host_db <= ~(8'h01 << adr);
      @(posedge clk_sys) sel_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      sel_n <= 1'b1;
      repeat (10) @(posedge clk_sys);
      host_db <= ~host_db;
   endtask
   task automatic put(input logic [7:0] b, input int hold,
                      output int n1, output int n2);
      wait_req(1'b0, n1);
      @(posedge clk_sys);
      ack_n <= 1'b0;
      host_db <= ~b;
      wait_req(1'b1, n2);
      repeat (hold) @(posedge clk_sys);
      @(posedge clk_sys);
      ack_n <= 1'b1;
      host_db <= b;
   endtask
   task automatic get(output logic [7:0] b, input int hold,
                      output int n1, output int n2, output int st);
      wait_req(1'b0, n1);
      b = ~db_n_in;
      st = stable;
      @(posedge clk_sys) ack_n <= 1'b0;
      wait_req(1'b1, n2);
      repeat (hold) @(posedge clk_sys);
      @(posedge clk_sys) ack_n <= 1'b1;
   endtask
endmodule

// File: verification/sasi_target_host_interface_bench.sv
// self-checking bench of the target-side host port
`timescale 1ns/10ps
`define CHECK(nm, ex, sn) \
   begin n_compared++; if ((sn) !== (ex)) begin bad_count++; \
   $display("wrong value %s expected %0h seen %0h", nm, ex, sn); end end
module sasi_target_host_interface_bench;
   import sasi_pkg::*;
   logic clk_sys, reset, sel_n, ack_n, busy_n, req_n, cd_n, io_n, msg_n;
   logic [7:0] db_n_in, db_n_out, tx_data, cmd_count;
   logic db_n_oe_n, cmd_valid, cmd_class_valid, cmd_unit, recal_on_fail;
   logic [2:0] cmd_class;
   logic [4:0] cmd_opcode;
   logic [20:0] cmd_logical_address;
   logic [1:0] retry_limit;
   logic reread_before_ecc, embedded_servo, step_code_valid, step_buffered;
   step_us_type step_period_us;
   logic tx_valid, tx_ready, done_valid, done_error, done_ready, selected;
   int bad_count = 0;
   int n_compared = 0;
   int n_cmd = 0;
   localparam int CTRL_ADDR_USED = 0;
   sasi_target_host_interface #(.CTRL_ADDR(CTRL_ADDR_USED))
      sasi_target_host_interface_inst (.*);
   host_adapter_model host_adapter_model_inst (.*);
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
      if (cmd_valid === 1'b1)
         n_cmd <= n_cmd + 1;
   task automatic report_and_stop;
      if (bad_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic push(input logic [7:0] d);
      @(posedge clk_sys) tx_valid <= 1'b1;
      tx_data <= d;
      @(posedge clk_sys) tx_valid <= 1'b0;
   endtask
   function automatic step_us_type exp_step(input logic [3:0] c);
      case (c)
         4'h4: return STEP_200_US;
         4'h5: return STEP_70_US;
         4'h6: return STEP_30_US;
         4'h7: return STEP_15_US;
         4'h8: return STEP_12_US;
         default: return STEP_DEFAULT_US;
      endcase
   endfunction
   // one byte to the host, checking setup, release and re-arm gap
   task automatic take(input logic [7:0] ex, input int hold, input bit gap);
      logic [7:0] b;
      int n1, n2, st;
      bit rel_ok, gap_ok;
      host_adapter_model_inst.get(b, hold, n1, n2, st);
      rel_ok = n2 > REQ_REL_CYC && n2 <= REQ_REL_MAX_CYC + 1;
      gap_ok = n1 >= REARM_CYC && n1 <= REARM_MAX_CYC;
      `CHECK("req_wait", 1'b1, n1 < 3000)
      `CHECK("byte", ex, b)
      `CHECK("setup", 1'b1, st >= DATA_SETUP_CYC)
      `CHECK("release", 1'b1, rel_ok)
      if (gap) `CHECK("gap", 1'b1, gap_ok)
   endtask
   task automatic run_cmd(input logic [3:0] i);
      block_type blk;
      logic [2:0] cls;
      int n1, n2, k, lim;
      cls = (i == 4'h2) ? 3'h3 : (i[0] ? 3'h7 : 3'h0);
      blk = {{i[0], i[1], 1'b0, i[2], i}, {4'h1, i}, {4'hc, i}, {4'h3, i},
             {2'h0, i[0], 1'b0, i}, {cls, 1'b0, i}};
      host_adapter_model_inst.select(CTRL_ADDR_USED);
      `CHECK("busy", 2'h1, {busy_n, selected})
      `CHECK("phase", 3'h3, {cd_n, io_n, msg_n})
      for (k = 0; k < CMD_BYTES; k++)
      begin
         host_adapter_model_inst.put(blk[k], (k == 2) ? 20 : 0, n1, n2);
         `CHECK("rx_release", 1'b1, n2 <= RX_REL_MAX_CYC + 1)
         lim = (k == 0) ? PHASE_REQ_CYC : NEXT_REQ_MAX_CYC + 1;
         `CHECK("next_req", 1'b1, n1 <= lim)
      end
      `CHECK("class", cls, cmd_class)
      `CHECK("opcode", {1'b0, i}, cmd_opcode)
      `CHECK("class_ok", cls == 3'h0 || cls == 3'h7, cmd_class_valid)
      `CHECK("unit", i[0], cmd_unit)
      `CHECK("address", {1'b0, i, 4'h3, i, 4'hc, i}, cmd_logical_address)
      `CHECK("count", {4'h1, i}, cmd_count)
      `CHECK("retry", i[0] ? 2'h0 : RETRY_COUNT, retry_limit)
      `CHECK("recal", ~i[0], recal_on_fail)
      `CHECK("reread", ~i[1], reread_before_ecc)
      `CHECK("servo", i[2], embedded_servo)
      `CHECK("step_ok", i == 4'h0 || (i >= 4'h4 && i <= 4'h8), step_code_valid)
      `CHECK("buffered", i >= 4'h4 && i <= 4'h8, step_buffered)
      `CHECK("step", exp_step(i), step_period_us)
      if (i == 4'h0)
      begin
         take(8'h5a, 0, 1'b0);
         take(8'ha5, 30, 1'b1);
      end
      @(posedge clk_sys) done_valid <= 1'b1;
      done_error <= i[1];
      n1 = 0;
      do
      begin
         @(negedge clk_sys);
         n1++;
      end
      while (done_ready !== 1'b1 && n1 < 500);
      `CHECK("done_ready", 1'b1, done_ready)
      @(posedge clk_sys) done_valid <= 1'b0;
      take({2'h0, i[0], 3'h0, i[1], 1'b0}, 0, 1'b0);
      `CHECK("status_phase", 2'h0, {cd_n, io_n})
      take(8'h00, 0, 1'b1);
      repeat (6) @(negedge clk_sys);
      `CHECK("idle", 3'h6, {busy_n, db_n_oe_n, selected})
   endtask
   initial
   begin
      reset = 1'b1;
      tx_valid = 1'b0;
      tx_data = 8'h00;
      done_valid = 1'b0;
      done_error = 1'b0;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      @(negedge clk_sys);
      `CHECK("reset", 4'hf, {busy_n, req_n, db_n_oe_n, tx_ready})
      repeat (2500) @(posedge clk_sys);
      push(8'h5a);
      push(8'ha5);
      @(negedge clk_sys);
      `CHECK("tx_full", 1'b0, tx_ready)
      host_adapter_model_inst.select(3);
      `CHECK("foreign", 1'b1, busy_n)
      for (int j = 0; j < 10; j++)
         run_cmd(j[3:0]);
      `CHECK("commands", 10, n_cmd)
      `CHECK("overlap", 0, host_adapter_model_inst.overlap)
      report_and_stop;
   end
   // whole run needs about 7600 cycles
   initial
   begin
      #600000;
      bad_count++;
      report_and_stop;
   end
endmodule
